// *** core/twowire_consts.svh ***
// constants shared by both ends of the two-wire register link
`ifndef TWOWIRE_CONSTS_SVH
`define TWOWIRE_CONSTS_SVH
`define TW_ADDR_DEF 7'h48
`define TW_ADDR_ALT 7'h5D
`define TW_DIR_WRITE 1'b0
`define TW_DIR_READ 1'b1
`define TW_ACK_BIT 4'h8
`define REG_AW 4
`define REG_WORDS 16
`define RST_PTR 16'h0000
`define CLK_PERIOD_NS 100
`define SCL_PERIOD_NS 2000
`define SCL_QTR_CYC \
  ((`SCL_PERIOD_NS + 4 * `CLK_PERIOD_NS - 1) / (4 * `CLK_PERIOD_NS))
`endif

// *** core/twowire_pkg.sv ***
// state types for both ends of the two-wire register link
package twowire_pkg;
  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} slv_st_e;
  typedef enum logic [2:0] {
    ROLE_DEV, ROLE_AH, ROLE_AL, ROLE_DH, ROLE_DL
  } role_e;
  typedef enum logic [3:0] {
    P_IDLE, P_START, P_DEVW, P_AH, P_AL, P_RS, P_DEVR, P_DATA, P_STOP
  } stage_e;
endpackage : twowire_pkg

// *** core/twowire_if.sv ***
// two-wire link between the bus master and the register slave
`timescale 1ns/1ps
interface twowire_if;
  logic scl;
  logic sda_m_oe;
  logic sda_m_out;
  logic sda_s_oe;
  logic sda_s_out;
  logic sda;
  // open drain with pull-up: any enabled low driver wins
  assign sda = !((sda_m_oe && !sda_m_out) || (sda_s_oe && !sda_s_out));
  modport master (output scl, output sda_m_oe, output sda_m_out,
                  input sda);
  modport slave (input scl, output sda_s_oe, output sda_s_out,
                 input sda);
endinterface : twowire_if

// *** core/twowire_slave.sv ***
// register slave end of the two-wire link
`timescale 1ns/1ps
`include "twowire_consts.svh"
// What this block does
// R1 - address byte lsb: 0 write, 1 read
// R2 - acknowledge only own seven-bit address
// R3 - two register address bytes, each acknowledged
// R4 - register address high byte first
// R5 - two data bytes acknowledged, register updated
// R6 - restart or stop ends a write
// R7 - random read: address write, restart, read
// R8 - read bytes driven, master acks, nack ends
// R9 - single read returns two bytes
// R10 - bare read uses the held address pointer
// R11 - sequential read supplies bytes until nack
// R12 - sequential write accepts words until stop
// R13 - select pin picks 0x90 or 0xBA
// R14 - msb first, eight bits plus ack
// R15 - receiver pulls low in ninth clock
// R16 - address advances after each word
module twowire_slave (
  input wire logic CLK,
  input wire logic SRST,
  twowire_if.slave BUS,
  input wire logic SLAVE_ADDR_SELECT,
  output logic WR_STROBE,
  output logic [15:0] WR_ADDR,
  output logic [15:0] WR_DATA
);
  import twowire_pkg::*;

  // --------------------------------------------------------------
  // pin synchronisers and edge finding
  // --------------------------------------------------------------
  logic scl_meta_reg, scl_meta_next;
  logic scl_reg, scl_next;
  logic sda_meta_reg, sda_meta_next;
  logic sda_reg, sda_next;
  logic sel_meta_reg, sel_meta_next;
  logic sel_reg, sel_next;
  logic scl_old_reg, scl_old_next;
  logic sda_old_reg, sda_old_next;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  always_comb begin
    scl_meta_next = BUS.scl;
    scl_next = scl_meta_reg;
    sda_meta_next = BUS.sda;
    sda_next = sda_meta_reg;
    sel_meta_next = SLAVE_ADDR_SELECT;
    sel_next = sel_meta_reg;
    scl_old_next = scl_reg;
    sda_old_next = sda_reg;
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      scl_meta_reg <= 1'b1;
      scl_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_reg <= 1'b1;
      sel_meta_reg <= 1'b0;
      sel_reg <= 1'b0;
      scl_old_reg <= 1'b1;
      sda_old_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_meta_next;
      scl_reg <= scl_next;
      sda_meta_reg <= sda_meta_next;
      sda_reg <= sda_next;
      sel_meta_reg <= sel_meta_next;
      sel_reg <= sel_next;
      scl_old_reg <= scl_old_next;
      sda_old_reg <= sda_old_next;
    end
  end
  assign rise = scl_reg && !scl_old_reg;
  assign fall = !scl_reg && scl_old_reg;
  // data edges while the clock stays high frame a transfer
  assign start = scl_reg && scl_old_reg && sda_old_reg && !sda_reg;
  assign stop = scl_reg && scl_old_reg && !sda_old_reg && sda_reg;

  // --------------------------------------------------------------
  // register store
  // --------------------------------------------------------------
  logic [15:0] mem [`REG_WORDS];
  logic mem_we;
  logic [`REG_AW-1:0] idx;
  logic [7:0] rd_byte;
  // --------------------------------------------------------------
  // byte engine
  // --------------------------------------------------------------
  slv_st_e st_reg, st_next;
  role_e role_reg, role_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] hi_reg, hi_next;
  logic [15:0] ptr_reg, ptr_next;
  logic rw_reg, rw_next;
  logic lo_reg, lo_next;
  logic oe_reg, oe_next;
  logic mack_reg, mack_next;
  logic wstb_reg, wstb_next;
  logic [15:0] waddr_reg, waddr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [6:0] own;
  assign idx = ptr_reg[`REG_AW-1:0];
  // high byte of a word goes out before its low byte
  assign rd_byte = lo_reg ? mem[idx][7:0] : mem[idx][15:8]; // R9
  assign own = sel_reg ? `TW_ADDR_ALT : `TW_ADDR_DEF; // R13
  always_comb begin
    st_next = st_reg;
    role_next = role_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    hi_next = hi_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    lo_next = lo_reg;
    oe_next = oe_reg;
    mack_next = mack_reg;
    wstb_next = 1'b0;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    mem_we = 1'b0;
    if (stop) begin
      st_next = S_IDLE; // R6
      oe_next = 1'b0;
    end else if (start) begin
      // a restart drops any half word and begins a new header
      st_next = S_RX; // R6
      role_next = ROLE_DEV;
      cnt_next = 4'h0;
      oe_next = 1'b0;
      lo_next = 1'b0;
    end else begin
      unique case (st_reg)
        S_IDLE: begin
        end
        S_RX: begin
          if (rise) begin
            sh_next = {sh_reg[6:0], sda_reg}; // R14
            cnt_next = cnt_reg + 4'h1;
          end else if (fall && cnt_reg == `TW_ACK_BIT) begin
            oe_next = 1'b1; // R15
            st_next = S_ACK;
            unique case (role_reg)
              ROLE_DEV: begin
                if (sh_reg[7:1] == own) begin // R2
                  rw_next = sh_reg[0]; // R1
                  role_next = ROLE_AH;
                end else begin
                  oe_next = 1'b0; // R2
                  st_next = S_IDLE;
                end
              end
              ROLE_AH: begin
                hi_next = sh_reg; // R3 R4
                role_next = ROLE_AL;
              end
              ROLE_AL: begin
                ptr_next = {hi_reg, sh_reg}; // R4
                role_next = ROLE_DH;
              end
              ROLE_DH: begin
                hi_next = sh_reg; // R5
                role_next = ROLE_DL;
              end
              ROLE_DL: begin
                mem_we = 1'b1; // R5
                wstb_next = 1'b1;
                waddr_next = ptr_reg;
                wdata_next = {hi_reg, sh_reg};
                ptr_next = ptr_reg + 16'h0001; // R16
                role_next = ROLE_DH; // R12
              end
            endcase
          end
        end
        S_ACK: begin
          if (fall) begin
            cnt_next = 4'h0;
            if (rw_reg == `TW_DIR_READ) begin
              // no address phase here, so the held pointer is used
              st_next = S_TX; // R10
              sh_next = rd_byte;
              oe_next = !rd_byte[7]; // R8
            end else begin
              st_next = S_RX;
              oe_next = 1'b0;
            end
          end
        end
        S_TX: begin
          if (rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (fall) begin
            if (cnt_reg == `TW_ACK_BIT) begin
              oe_next = 1'b0; // R15
              st_next = S_MACK;
              lo_next = !lo_reg;
              if (lo_reg) begin
                ptr_next = ptr_reg + 16'h0001; // R16
              end
            end else begin
              sh_next = {sh_reg[6:0], 1'b0}; // R14
              oe_next = !sh_reg[6];
            end
          end
        end
        S_MACK: begin
          if (rise) begin
            mack_next = !sda_reg; // R8
          end else if (fall) begin
            if (mack_reg) begin
              st_next = S_TX; // R11
              cnt_next = 4'h0;
              sh_next = rd_byte;
              oe_next = !rd_byte[7];
            end else begin
              st_next = S_IDLE; // R8
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_reg <= S_IDLE;
      role_reg <= ROLE_DEV;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      hi_reg <= 8'h00;
      ptr_reg <= `RST_PTR;
      rw_reg <= `TW_DIR_WRITE;
      lo_reg <= 1'b0;
      oe_reg <= 1'b0;
      mack_reg <= 1'b0;
      wstb_reg <= 1'b0;
      waddr_reg <= 16'h0000;
      wdata_reg <= 16'h0000;
    end else begin
      st_reg <= st_next;
      role_reg <= role_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      hi_reg <= hi_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      lo_reg <= lo_next;
      oe_reg <= oe_next;
      mack_reg <= mack_next;
      wstb_reg <= wstb_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
    end
  end
  // store holds data only, so it needs no reset
  always_ff @(posedge CLK) begin
    if (mem_we) begin
      mem[idx] <= wdata_next;
    end
  end

  assign BUS.sda_s_oe = oe_reg;
  assign BUS.sda_s_out = 1'b0;
  assign WR_STROBE = wstb_reg;
  assign WR_ADDR = waddr_reg;
  assign WR_DATA = wdata_reg;
endmodule : twowire_slave

// *** core/twowire_master.sv ***
// bus master end of the two-wire link
`timescale 1ns/1ps
`include "twowire_consts.svh"
module twowire_master (
  input wire logic CLK,
  input wire logic SRST,
  twowire_if.master BUS,
  input wire logic CMD_VALID,
  input wire logic CMD_READ,
  input wire logic CMD_CURRENT,
  input wire logic [6:0] CMD_DEV_ADDR,
  input wire logic [15:0] CMD_REG_ADDR,
  input wire logic [15:0] CMD_WDATA,
  input wire logic [7:0] CMD_WORDS,
  output logic BUSY,
  output logic WDATA_TAKEN,
  output logic RD_VALID,
  output logic [15:0] RD_DATA,
  output logic NACK_ERR
);
  import twowire_pkg::*;

  // --------------------------------------------------------------
  // byte selection for each stage
  // --------------------------------------------------------------
  function automatic logic [7:0] tx_byte(input stage_e s,
      input logic [6:0] dev, input logic [15:0] ra,
      input logic [15:0] wd, input logic lo);
    logic [7:0] b;
    b = 8'h00;
    unique case (s)
      P_DEVW: b = {dev, `TW_DIR_WRITE}; // R1
      P_AH: b = ra[15:8]; // R3
      P_AL: b = ra[7:0];
      P_DEVR: b = {dev, `TW_DIR_READ}; // R1
      P_DATA: b = lo ? wd[7:0] : wd[15:8]; // R5
      P_IDLE, P_START, P_RS, P_STOP: b = 8'h00;
    endcase
    return b;
  endfunction : tx_byte

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  stage_e stage_reg, stage_next;
  logic [3:0] tick_reg, tick_next;
  logic [1:0] q_reg, q_next;
  logic [3:0] bit_reg, bit_next;
  logic read_reg, read_next;
  logic cur_reg, cur_next;
  logic [6:0] dev_reg, dev_next;
  logic [15:0] ra_reg, ra_next;
  logic [15:0] wd_reg, wd_next;
  logic [7:0] left_reg, left_next;
  logic lo_reg, lo_next;
  logic [7:0] rx_reg, rx_next;
  logic [7:0] rhi_reg, rhi_next;
  logic scl_reg, scl_next;
  logic oe_reg, oe_next;
  logic busy_reg, busy_next;
  logic take_reg, take_next;
  logic rdv_reg, rdv_next;
  logic [15:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic sda_meta_reg;
  logic sda_reg;
  logic tick;
  logic acked;
  logic [7:0] b;

  assign tick = tick_reg == 4'(`SCL_QTR_CYC - 1);
  assign acked = !sda_reg; // R15

  always_comb begin
    stage_next = stage_reg;
    tick_next = 4'h0;
    q_next = q_reg;
    bit_next = bit_reg;
    read_next = read_reg;
    cur_next = cur_reg;
    dev_next = dev_reg;
    ra_next = ra_reg;
    wd_next = wd_reg;
    left_next = left_reg;
    lo_next = lo_reg;
    rx_next = rx_reg;
    rhi_next = rhi_reg;
    busy_next = busy_reg;
    take_next = 1'b0;
    rdv_next = 1'b0;
    rdata_next = rdata_reg;
    err_next = err_reg;
    b = 8'h00;
    if (stage_reg == P_IDLE) begin
      if (CMD_VALID) begin
        stage_next = P_START;
        q_next = 2'd0;
        bit_next = 4'h0;
        read_next = CMD_READ;
        cur_next = CMD_CURRENT;
        dev_next = CMD_DEV_ADDR;
        ra_next = CMD_REG_ADDR;
        wd_next = CMD_WDATA;
        take_next = !CMD_READ;
        left_next = CMD_WORDS;
        lo_next = 1'b0;
        busy_next = 1'b1;
        err_next = 1'b0;
      end
    end else if (!tick) begin
      tick_next = tick_reg + 4'h1;
    end else begin
      q_next = q_reg + 2'd1;
      if (q_reg == 2'd3 && stage_reg != P_START && stage_reg != P_RS
          && stage_reg != P_STOP) begin
        if (read_reg && stage_reg == P_DATA && bit_reg != `TW_ACK_BIT)
        begin
          rx_next = {rx_reg[6:0], sda_reg}; // R14
        end
        bit_next = bit_reg + 4'h1;
      end
      if (q_reg == 2'd3) begin
        unique case (stage_reg)
          P_IDLE: begin
          end
          P_START: stage_next = (read_reg && cur_reg) ? P_DEVR : P_DEVW;
          P_RS: stage_next = P_DEVR; // R7
          P_STOP: begin
            stage_next = P_IDLE;
            busy_next = 1'b0;
          end
          P_DEVW, P_AH, P_AL, P_DEVR, P_DATA: begin
            if (bit_reg == `TW_ACK_BIT) begin
              bit_next = 4'h0;
              if (!(read_reg && stage_reg == P_DATA) && !acked) begin
                stage_next = P_STOP;
                err_next = 1'b1;
              end else if (stage_reg == P_DEVW) begin
                stage_next = P_AH; // R3
              end else if (stage_reg == P_AH) begin
                stage_next = P_AL;
              end else if (stage_reg == P_AL) begin
                stage_next = read_reg ? P_RS : P_DATA; // R7
              end else if (stage_reg == P_DEVR) begin
                stage_next = P_DATA;
              end else begin
                lo_next = !lo_reg;
                if (!read_reg) begin
                  rhi_next = rhi_reg;
                end else if (!lo_reg) begin
                  rhi_next = rx_reg;
                end else begin
                  rdata_next = {rhi_reg, rx_reg};
                  rdv_next = 1'b1;
                end
                if (lo_reg) begin
                  left_next = left_reg - 8'd1;
                  if (left_reg == 8'd1) begin
                    stage_next = P_STOP; // R6 R12
                  end else if (!read_reg) begin
                    wd_next = CMD_WDATA; // R12
                    take_next = 1'b1;
                  end
                end
              end
            end
          end
        endcase
      end
    end
    // pin levels follow the state being entered
    scl_next = 1'b1;
    oe_next = 1'b0;
    unique case (stage_next)
      P_IDLE: begin
      end
      P_START, P_RS: begin
        scl_next = q_next == 2'd1 || q_next == 2'd2;
        oe_next = q_next[1];
      end
      P_STOP: begin
        scl_next = q_next != 2'd0;
        oe_next = !q_next[1]; // R6
      end
      P_DEVW, P_AH, P_AL, P_DEVR, P_DATA: begin
        scl_next = q_next[1];
        b = tx_byte(stage_next, dev_next, ra_next, wd_next, lo_next);
        if (read_next && stage_next == P_DATA) begin
          // last byte of the last word gets no acknowledge
          oe_next = bit_next == `TW_ACK_BIT
                    && !(lo_next && left_next == 8'd1); // R8 R11
        end else if (bit_next != `TW_ACK_BIT) begin
          oe_next = !b[3'(4'd7 - bit_next)]; // R14
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      stage_reg <= P_IDLE;
      tick_reg <= 4'h0;
      q_reg <= 2'd0;
      bit_reg <= 4'h0;
      read_reg <= 1'b0;
      cur_reg <= 1'b0;
      dev_reg <= 7'h00;
      ra_reg <= 16'h0000;
      wd_reg <= 16'h0000;
      left_reg <= 8'h00;
      lo_reg <= 1'b0;
      rx_reg <= 8'h00;
      rhi_reg <= 8'h00;
      scl_reg <= 1'b1;
      oe_reg <= 1'b0;
      busy_reg <= 1'b0;
      take_reg <= 1'b0;
      rdv_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      err_reg <= 1'b0;
      sda_meta_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      stage_reg <= stage_next;
      tick_reg <= tick_next;
      q_reg <= q_next;
      bit_reg <= bit_next;
      read_reg <= read_next;
      cur_reg <= cur_next;
      dev_reg <= dev_next;
      ra_reg <= ra_next;
      wd_reg <= wd_next;
      left_reg <= left_next;
      lo_reg <= lo_next;
      rx_reg <= rx_next;
      rhi_reg <= rhi_next;
      scl_reg <= scl_next;
      oe_reg <= oe_next;
      busy_reg <= busy_next;
      take_reg <= take_next;
      rdv_reg <= rdv_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
      sda_meta_reg <= BUS.sda;
      sda_reg <= sda_meta_reg;
    end
  end

  assign BUS.scl = scl_reg;
  assign BUS.sda_m_oe = oe_reg;
  assign BUS.sda_m_out = 1'b0;
  assign BUSY = busy_reg;
  assign WDATA_TAKEN = take_reg;
  assign RD_VALID = rdv_reg;
  assign RD_DATA = rdata_reg;
  assign NACK_ERR = err_reg;
endmodule : twowire_master

// *** testbench/twowire_link_assertions.sv ***
// concurrent checks on the wires of the two-wire link
`timescale 1ns/1ps
module twowire_link_assertions (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic scl,
  input wire logic sda_m_oe,
  input wire logic sda_m_out,
  input wire logic sda_s_oe,
  input wire logic sda_s_out,
  input wire logic sda
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  // ------------------------------------------------------------
  // bus conditions
  // ------------------------------------------------------------
  sequence start_seq;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_seq;
    scl && $past(scl) && $rose(sda);
  endsequence
  sequence low_phase_seq;
    (!scl)[*4];
  endsequence

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  m_open_drain_a: assert property (sda_m_oe |-> !sda_m_out && !sda)
    else $error("master drive did not pull sda low");
  s_open_drain_a: assert property (sda_s_oe |-> !sda_s_out && !sda)
    else $error("slave drive did not pull sda low");
  // receiver may only pull sda once the transmitter has let go
  ack_after_release_a: assert property (
    $rose(sda_s_oe) |-> !sda_m_oe)
    else $error("slave pulled sda while master still drove it");
  slave_release_a: assert property (
    $rose(sda_s_oe) |-> ##[1:200] !sda_s_oe)
    else $error("slave held sda low too long");
  // slave may only move sda well inside the low phase
  slave_lag_low_a: assert property (
    $changed(sda_s_oe) |-> !scl && !$past(scl) && !$past(scl, 2))
    else $error("slave changed sda near scl high");
  master_edge_a: assert property (
    $changed(sda_m_oe) && scl |-> $past(scl, 3))
    else $error("master changed sda while scl high");
  start_then_low_a: assert property (
    start_seq |-> scl ##[2:8] !scl)
    else $error("scl did not fall after start");
  stop_holds_high_a: assert property (stop_seq |-> scl[*8])
    else $error("scl not held high after stop");
  scl_high_min_a: assert property ($rose(scl) |-> scl[*8])
    else $error("scl high phase too short");
  scl_low_min_a: assert property ($fell(scl) |-> low_phase_seq)
    else $error("scl low phase too short");
  cover property (start_seq ##[1:400] stop_seq);
endmodule : twowire_link_assertions

// *** testbench/twowire_slave_reg_access_test.sv ***
// self-checking bench joining master and slave ends of the link
`timescale 1ns/1ps
`include "twowire_consts.svh"
module twowire_slave_reg_access_test;
  import twowire_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid, cmd_read, cmd_current, addr_sel;
  logic [6:0] cmd_dev;
  logic [15:0] cmd_ra, cmd_wd, wbase, rd_data, wr_addr, wr_data;
  logic [7:0] cmd_words, hdr, sh;
  logic busy, wdata_taken, rd_valid, nack_err, wr_strobe;
  logic hdr_ack, scl_d, sda_d;
  logic [15:0] wr_a_q[$], wr_d_q[$], rd_q[$];
  int fails = 0;
  int samples_checked = 0;
  int widx = 0;
  int bitn = 99;

  twowire_if i_twowire_if ();
  twowire_master i_twowire_master (.CLK(clk), .SRST(srst),
    .BUS(i_twowire_if.master), .CMD_VALID(cmd_valid),
    .CMD_READ(cmd_read), .CMD_CURRENT(cmd_current),
    .CMD_DEV_ADDR(cmd_dev), .CMD_REG_ADDR(cmd_ra), .CMD_WDATA(cmd_wd),
    .CMD_WORDS(cmd_words), .BUSY(busy), .WDATA_TAKEN(wdata_taken),
    .RD_VALID(rd_valid), .RD_DATA(rd_data), .NACK_ERR(nack_err));
  twowire_slave i_twowire_slave (.CLK(clk), .SRST(srst),
    .BUS(i_twowire_if.slave), .SLAVE_ADDR_SELECT(addr_sel),
    .WR_STROBE(wr_strobe), .WR_ADDR(wr_addr), .WR_DATA(wr_data));
  twowire_link_assertions i_twowire_link_assertions (.CLK(clk),
    .SRST(srst), .scl(i_twowire_if.scl), .sda_m_oe(i_twowire_if.sda_m_oe),
    .sda_m_out(i_twowire_if.sda_m_out), .sda_s_oe(i_twowire_if.sda_s_oe),
    .sda_s_out(i_twowire_if.sda_s_out), .sda(i_twowire_if.sda));

  initial begin
    forever #50 clk = ~clk;
  end

  // ------------------------------------------------------------
  // monitors, sampled mid-cycle so flops have settled
  // ------------------------------------------------------------
  always @(negedge clk) begin
    if (wr_strobe === 1'b1) begin
      wr_a_q.push_back(wr_addr);
      wr_d_q.push_back(wr_data);
    end
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    if (wdata_taken === 1'b1) begin
      widx++;
      cmd_wd = wbase + 16'(widx);
    end
    // first byte after each start and its acknowledge, seen on the wire
    if (scl_d && i_twowire_if.scl && sda_d && !i_twowire_if.sda) bitn = 0;
    else if (!scl_d && i_twowire_if.scl) begin
      if (bitn == 7) hdr = {sh[6:0], i_twowire_if.sda};
      if (bitn == 8) hdr_ack = i_twowire_if.sda;
      sh = {sh[6:0], i_twowire_if.sda};
      bitn++;
    end
    scl_d = i_twowire_if.scl;
    sda_d = i_twowire_if.sda;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // one command on the master's port, waits until the bus is released
  task automatic run(input logic rd, input logic cur, input logic [6:0] dev,
                     input logic [15:0] ra, input logic [15:0] wb,
                     input logic [7:0] n);
    int k;
    wr_a_q.delete();
    wr_d_q.delete();
    rd_q.delete();
    @(negedge clk);
    cmd_read = rd;
    cmd_current = cur;
    cmd_dev = dev;
    cmd_ra = ra;
    wbase = wb;
    widx = 0;
    cmd_wd = wb;
    cmd_words = n;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (2) @(negedge clk);
    k = 0;
    while (busy !== 1'b0 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 20000) begin
      fails++;
      $display("[FAIL] %0t command never finished", $time);
    end
  endtask : run

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_single();
    run(1'b0, 1'b0, `TW_ADDR_DEF, 16'h0003, 16'ha5c3, 8'h01);
    check(16'(wr_a_q.size()), 16'h0001);
    check(wr_a_q[0], 16'h0003);
    check(wr_d_q[0], 16'ha5c3);
    check({8'h00, hdr}, {8'h00, `TW_ADDR_DEF, `TW_DIR_WRITE});
    check({15'h0000, hdr_ack}, 16'h0000);
    check({15'h0000, nack_err}, 16'h0000);
    run(1'b1, 1'b0, `TW_ADDR_DEF, 16'h0003, 16'h0000, 8'h01);
    check(16'(wr_a_q.size()), 16'h0000);
    check(16'(rd_q.size()), 16'h0001);
    check(rd_q[0], 16'ha5c3);
    check({8'h00, hdr}, {8'h00, `TW_ADDR_DEF, `TW_DIR_READ});
    $display("test single done");
  endtask : t_single

  task automatic t_sequential();
    run(1'b0, 1'b0, `TW_ADDR_DEF, 16'h0005, 16'h1230, 8'h04);
    check(16'(wr_a_q.size()), 16'h0004);
    for (int k = 0; k < 4; k++) begin
      check(wr_a_q[k], 16'h0005 + 16'(k));
      check(wr_d_q[k], 16'h1230 + 16'(k));
    end
    run(1'b1, 1'b0, `TW_ADDR_DEF, 16'h0005, 16'h0000, 8'h03);
    check(16'(rd_q.size()), 16'h0003);
    for (int k = 0; k < 3; k++) check(rd_q[k], 16'h1230 + 16'(k));
    // pointer was left one past the last word read
    run(1'b1, 1'b1, `TW_ADDR_DEF, 16'h0000, 16'h0000, 8'h01);
    check(rd_q[0], 16'h1233);
    check({15'h0000, nack_err}, 16'h0000);
    $display("test sequential done");
  endtask : t_sequential

  task automatic t_select();
    run(1'b0, 1'b0, `TW_ADDR_ALT, 16'h000a, 16'h5a5a, 8'h01);
    check({15'h0000, nack_err}, 16'h0001);
    check({15'h0000, hdr_ack}, 16'h0001);
    check(16'(wr_a_q.size()), 16'h0000);
    @(negedge clk);
    addr_sel = 1'b1;
    repeat (10) @(negedge clk);
    run(1'b0, 1'b0, `TW_ADDR_ALT, 16'h000a, 16'h5a5a, 8'h01);
    check({15'h0000, nack_err}, 16'h0000);
    check(wr_d_q[0], 16'h5a5a);
    run(1'b0, 1'b0, `TW_ADDR_DEF, 16'h000a, 16'h1111, 8'h01);
    check({15'h0000, nack_err}, 16'h0001);
    check(16'(wr_a_q.size()), 16'h0000);
    addr_sel = 1'b0;
    $display("test select done");
  endtask : t_select

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_current = 1'b0;
    cmd_dev = 7'h00;
    cmd_ra = 16'h0000;
    cmd_wd = 16'h0000;
    wbase = 16'h0000;
    cmd_words = 8'h01;
    addr_sel = 1'b0;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    repeat (5) @(negedge clk);
    t_single();
    t_sequential();
    t_select();
    results();
  end

  // about four times the expected run length
  initial begin
    #3000000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
endmodule : twowire_slave_reg_access_test
